// [design/dsadc_ctrl.sv]
// Dual slope converter sequencer, result buffer and digit multiplexer
`timescale 1ns/1ns
`default_nettype none

// ======================================================
// Result buffer
module dsadc_fifo #(
    parameter int unsigned W = 12,
    parameter int unsigned D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    assign inReady  = (cnt_r != (AW+1)'(D));
    assign outValid = (cnt_r != '0);
    assign outData  = mem_r[rp_r];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointer and fill bookkeeping
    always_comb
    begin
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (AW+1)'(cnt_r + {AW'(0), push} - {AW'(0), pop});
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= inData;
    end
endmodule

// ======================================================
module dsadc_ctrl #(
    parameter int unsigned OSC_DIV = dsadc_pkg::OSC_DIV_CYC,
    parameter int unsigned DEPTH   = dsadc_pkg::FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] modeSel,
    input  wire logic       compAbove,
    output logic            integIn,
    output logic            integRef,
    output logic            refNegative,
    output logic [3:0]      bcd,
    output logic            topDigitSelect_n,
    output logic            middleDigitSelect_n,
    output logic            bottomDigitSelect_n
);
    localparam int CONV_MAX = 100100;
    localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);
    localparam logic [5:0]  CNT_LAST = 6'(dsadc_pkg::CNT_DIV_CYC - 1);
    localparam logic [9:0]  INT_LAST = 10'(dsadc_pkg::INT_COUNTS - 1);

    dsadc_pkg::dsadc_state_t  st_r, st_nxt;
    dsadc_pkg::dsadc_digits_t res_r, res_nxt, shown_r, shown_nxt, fifoData;
    logic [15:0] osc_r, osc_nxt;
    logic [5:0]  pre_r, pre_nxt;
    logic [7:0]  per_r, per_nxt;
    logic [9:0]  cnt_r, cnt_nxt;
    logic [1:0]  dig_r, dig_nxt;
    logic [2:0]  sel_r, sel_nxt;
    logic [3:0]  bcd_r, bcd_nxt;
    logic        oscTick, cntTick, perDone_r, perDone_nxt, pos_r, pos_nxt;
    logic        holdMode, start, crossed, limitHit, push, pushReady;
    logic        fifoValid, pop;
    logic [7:0]  perLast;

    // Build result digits from a count; overrange fills every digit
    function automatic dsadc_pkg::dsadc_digits_t toDigits(
        input logic [9:0] c,
        input logic       neg,
        input logic       ovr
    );
        dsadc_pkg::dsadc_digits_t d;
        d.top = 4'(c / 10'd100);
        d.mid = 4'((c / 10'd10) % 10'd10);
        d.bot = 4'(c % 10'd10);
        if (ovr)
            d = neg ? {3{dsadc_pkg::CODE_NOVR}} : {3{dsadc_pkg::CODE_POVR}};
        else if (neg)
            d.top = dsadc_pkg::CODE_MINUS;
        return d;
    endfunction

    // ======================================================
    // Timebase: oscillator tick and count tick
    assign oscTick = (osc_r == OSC_LAST);
    assign cntTick = (pre_r == CNT_LAST);
    assign holdMode = (modeSel == dsadc_pkg::MODE_HOLD);
    // Fast only for MODE_FAST (2'h2); hold and code 2'h3 keep the slow cadence
    assign perLast = (modeSel == dsadc_pkg::MODE_FAST) ?
                     8'(dsadc_pkg::FAST_TICKS - 1) : 8'(dsadc_pkg::SLOW_TICKS - 1);

    always_comb
    begin
        osc_nxt = oscTick ? '0 : 16'(osc_r + 1'b1);
        pre_nxt = cntTick ? '0 : 6'(pre_r + 1'b1);
        per_nxt = per_r;
        if (oscTick)
            per_nxt = (per_r >= perLast) ? '0 : 8'(per_r + 1'b1);
        // A period end that meets a start is kept; start clears only the old one
        perDone_nxt = (perDone_r && !start) || (oscTick && per_r >= perLast);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_r     <= '0;
            pre_r     <= '0;
            per_r     <= '0;
            perDone_r <= 1'b0;
        end
        else
        begin
            osc_r     <= osc_nxt;
            pre_r     <= pre_nxt;
            per_r     <= per_nxt;
            perDone_r <= perDone_nxt;
        end
    end

    // ======================================================
    // Conversion sequencer
    // Start waits for buffer room so a finished result is never dropped
    assign start    = (st_r == dsadc_pkg::ST_IDLE) && perDone_r && pushReady;
    assign crossed  = (compAbove != pos_r);
    assign limitHit = (cnt_r == (pos_r ? dsadc_pkg::POS_MAX : dsadc_pkg::NEG_MAX));
    assign push     = (st_r == dsadc_pkg::ST_DONE);
    assign integIn  = (st_r == dsadc_pkg::ST_INTEG);
    assign integRef = (st_r == dsadc_pkg::ST_DEINT);
    assign refNegative = pos_r;

    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        pos_nxt = pos_r;
        res_nxt = res_r;
        unique case (st_r)
            dsadc_pkg::ST_IDLE:
                if (start)
                begin
                    st_nxt  = dsadc_pkg::ST_INTEG;
                    cnt_nxt = '0;
                end
            dsadc_pkg::ST_INTEG:
                if (cntTick)
                begin
                    if (cnt_r == INT_LAST)
                    begin
                        st_nxt  = dsadc_pkg::ST_DEINT;
                        cnt_nxt = '0;
                        pos_nxt = compAbove;
                    end
                    else
                        cnt_nxt = 10'(cnt_r + 1'b1);
                end
            dsadc_pkg::ST_DEINT:
                if (cntTick)
                begin
                    if (crossed)
                    begin
                        st_nxt  = dsadc_pkg::ST_DONE;
                        res_nxt = toDigits(cnt_r, !pos_r, 1'b0);
                    end
                    else if (limitHit)
                    begin
                        st_nxt  = dsadc_pkg::ST_DONE;
                        res_nxt = toDigits(cnt_r, !pos_r, 1'b1);
                    end
                    else
                        cnt_nxt = 10'(cnt_r + 1'b1);
                end
            dsadc_pkg::ST_DONE:
                st_nxt = dsadc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r  <= dsadc_pkg::ST_IDLE;
            cnt_r <= '0;
            pos_r <= 1'b1;
            res_r <= '0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            pos_r <= pos_nxt;
            res_r <= res_nxt;
        end
    end

    dsadc_fifo #(
        .W (12),
        .D (DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inValid  (push),
        .inReady  (pushReady),
        .inData   (res_r),
        .outValid (fifoValid),
        .outReady (pop),
        .outData  (fifoData)
    );

    // ======================================================
    // Display multiplexer
    // Results are drained once per frame; in hold they are read and dropped
    assign pop = oscTick && (dig_r == 2'h2);

    always_comb
    begin
        shown_nxt = shown_r;
        if (pop && fifoValid && !holdMode)
            shown_nxt = fifoData;
        dig_nxt = dig_r;
        sel_nxt = sel_r;
        bcd_nxt = bcd_r;
        // Select and data change on the same edge so data is steady under a select
        if (oscTick)
        begin
            dig_nxt = (dig_r == 2'h2) ? 2'h0 : 2'(dig_r + 1'b1);
            unique case (dig_nxt)
                2'h0:
                begin
                    sel_nxt = 3'h6;
                    bcd_nxt = shown_nxt.top;
                end
                2'h1:
                begin
                    sel_nxt = 3'h5;
                    bcd_nxt = shown_nxt.mid;
                end
                default:
                begin
                    sel_nxt = 3'h3;
                    bcd_nxt = shown_nxt.bot;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shown_r <= '0;
            dig_r   <= '0;
            sel_r   <= dsadc_pkg::SEL_RST;
            bcd_r   <= '0;
        end
        else
        begin
            shown_r <= shown_nxt;
            dig_r   <= dig_nxt;
            sel_r   <= sel_nxt;
            bcd_r   <= bcd_nxt;
        end
    end

    assign bcd                 = bcd_r;
    assign topDigitSelect_n    = sel_r[0];
    assign middleDigitSelect_n = sel_r[1];
    assign bottomDigitSelect_n = sel_r[2];

    // ======================================================
    // Checks
    logic [16:0] conv_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_r <= '0;
        else
            conv_r <= (st_r == dsadc_pkg::ST_IDLE) ? '0 : 17'(conv_r + 1'b1);
    end

    a_sel_onecold: assert property (@(posedge clk) disable iff (!rst_n)
        $countones(sel_r) == 2) else $error("digit selects not one-cold");
    a_bcd_steady: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(sel_r) |-> $stable(bcd_r)) else $error("bcd moved under select");
    a_integ_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        (integIn && cntTick && cnt_r == INT_LAST) |=> integRef && cnt_r == 10'h000)
        else $error("integrate length wrong");
    a_capture_cnt: assert property (@(posedge clk) disable iff (!rst_n)
        (integRef && cntTick && crossed && pos_r && cnt_r < 10'h064)
        |=> push && res_r.bot == 4'($past(cnt_r) % 10'd10)) else $error("capture wrong");
    a_pos_ovr: assert property (@(posedge clk) disable iff (!rst_n)
        (integRef && cntTick && !crossed && pos_r && cnt_r == dsadc_pkg::POS_MAX)
        |=> res_r == {3{dsadc_pkg::CODE_POVR}}) else $error("positive overrange code");
    a_neg_ovr: assert property (@(posedge clk) disable iff (!rst_n)
        (integRef && cntTick && !crossed && !pos_r && cnt_r == dsadc_pkg::NEG_MAX)
        |=> res_r == {3{dsadc_pkg::CODE_NOVR}}) else $error("negative overrange code");
    a_no_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        integRef |-> cnt_r <= dsadc_pkg::POS_MAX) else $error("count passed top");
    a_neg_sign: assert property (@(posedge clk) disable iff (!rst_n)
        (integRef && cntTick && crossed && !pos_r)
        |=> res_r.top == dsadc_pkg::CODE_MINUS) else $error("minus sign missing");
    a_hold_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        (pop && holdMode) |=> $stable(shown_r)) else $error("display moved in hold");
    a_live_update: assert property (@(posedge clk) disable iff (!rst_n)
        (pop && fifoValid && !holdMode) |=> shown_r == $past(fifoData))
        else $error("display not updated");
    a_start_period: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(integIn) |-> $past(perDone_r)) else $error("start without period");
    a_conv_time: assert property (@(posedge clk) disable iff (!rst_n)
        push |-> conv_r <= CONV_MAX) else $error("conversion too long");
endmodule
`default_nettype wire

// [pkg/dsadc_pkg.sv]
// Constants and types shared by the dual slope converter control
package dsadc_pkg;
    // ======================================================
    // Timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned OSC_HZ       = 786;
    localparam int unsigned OSC_DIV_CYC  = CLK_HZ / OSC_HZ;
    localparam int unsigned FAST_HZ      = 96;
    localparam int unsigned SLOW_HZ      = 4;
    localparam int unsigned FAST_TICKS   = OSC_HZ / FAST_HZ;
    localparam int unsigned SLOW_TICKS   = OSC_HZ / SLOW_HZ;
    localparam int unsigned CONV_US      = 5000;
    localparam int unsigned CONV_STEPS   = 2000;
    localparam int unsigned CNT_DIV_CYC  = (CLK_HZ / 1_000_000) * CONV_US / CONV_STEPS;
    localparam int unsigned INT_COUNTS   = 1000;
    // ======================================================
    // Range limits and codes
    localparam logic [9:0] POS_MAX   = 10'h3e7;
    localparam logic [9:0] NEG_MAX   = 10'h063;
    localparam logic [3:0] CODE_NOVR = 4'ha;
    localparam logic [3:0] CODE_POVR = 4'hb;
    localparam logic [3:0] CODE_MINUS = 4'ha;
    localparam logic [2:0] SEL_IDLE  = 3'h7;
    localparam logic [2:0] SEL_RST   = 3'h6;
    localparam int unsigned FIFO_DEPTH = 16;
    // ======================================================
    // Types
    typedef enum logic [1:0] {
        MODE_SLOW = 2'h0,
        MODE_HOLD = 2'h1,
        MODE_FAST = 2'h2
    } dsadc_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_INTEG = 2'h1,
        ST_DEINT = 2'h3,
        ST_DONE  = 2'h2
    } dsadc_state_t;
    typedef struct packed {
        logic [3:0] top;
        logic [3:0] mid;
        logic [3:0] bot;
    } dsadc_digits_t;
endpackage

// [verif/dsadc_latch_model.sv]
// Model of the outside per-digit latches that catch the multiplexed BCD bus
`timescale 1ns/1ns
`default_nettype none

// ======================================================
// Digit latches
module dsadc_latch_model (
    input  wire logic       clk,
    input  wire logic [3:0] bcd,
    input  wire logic       topDigitSelect_n,
    input  wire logic       middleDigitSelect_n,
    input  wire logic       bottomDigitSelect_n,
    output logic [3:0]      topHeld,
    output logic [3:0]      midHeld,
    output logic [3:0]      botHeld
);
    // Loads bcd on each rising clock edge while the inverted select is low, holds once it rises; no reset,
    // so a digit reads unknown until its first slot has passed
    always_ff @(posedge clk)
    begin
        if (!topDigitSelect_n) topHeld <= bcd;
        if (!middleDigitSelect_n) midHeld <= bcd;
        if (!bottomDigitSelect_n) botHeld <= bcd;
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the dual slope converter control
`timescale 1ns/1ns
`default_nettype none

// ======================================================
// Bench top
module tb;
    localparam int unsigned DIV   = 20;
    localparam int unsigned TICK  = dsadc_pkg::CNT_DIV_CYC;
    localparam int unsigned LIMIT = 120000;
    logic        clk;
    logic        rst_n;
    logic [1:0]  modeSel;
    logic        compAbove;
    logic        integIn;
    logic        integRef;
    logic        refNegative;
    logic [3:0]  bcd;
    logic        topSel_n;
    logic        midSel_n;
    logic        botSel_n;
    logic [3:0]  topHeld;
    logic [3:0]  midHeld;
    logic [3:0]  botHeld;
    logic [3:0]  bcdPrev;
    logic [2:0]  selPrev;
    logic        inPrev;
    int          integLen;
    logic [31:0] rng;
    int          n_fail;
    int          n_compared;
    int          cycles;
    int          n;

    // Short oscillator divider keeps the display slots a few clocks long
    dsadc_ctrl #(.OSC_DIV(DIV)) i_dsadc_ctrl (
        .clk                 (clk),
        .rst_n               (rst_n),
        .modeSel             (modeSel),
        .compAbove           (compAbove),
        .integIn             (integIn),
        .integRef            (integRef),
        .refNegative         (refNegative),
        .bcd                 (bcd),
        .topDigitSelect_n    (topSel_n),
        .middleDigitSelect_n (midSel_n),
        .bottomDigitSelect_n (botSel_n)
    );
    dsadc_latch_model i_dsadc_latch_model (
        .clk                 (clk),
        .bcd                 (bcd),
        .topDigitSelect_n    (topSel_n),
        .middleDigitSelect_n (midSel_n),
        .bottomDigitSelect_n (botSel_n),
        .topHeld             (topHeld),
        .midHeld             (midHeld),
        .botHeld             (botHeld)
    );

    // ======================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Integrate phase: comparator noise is ignored until the end, then pol is held
    task automatic integrate(input logic pol);
        n = 0;
        while (integIn === 1'b1 && n < 52000)
        begin
            @(posedge clk);
            rng = xs(rng);
            compAbove <= (n < 49000) ? rng[0] : pol;
            n++;
        end
        @(negedge clk);
        // Length is counted by the monitor from the rise, so a late call still sees it whole
        check({31'h0, integLen >= 49950 && integLen <= 50050}, 32'h1);
        check({30'h0, integRef, refNegative}, {30'h0, 1'b1, pol});
    endtask

    task automatic waitRefDone(input int maxc);
        n = 0;
        while (integRef === 1'b1 && n < maxc)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    // ======================================================
    // Clock, timeout and display monitor
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            $display("[ERR] t=%0t cycle limit reached", $time);
            summarize();
        end
    end

    // Selects one at a time, data steady while the same select stays low
    always @(posedge clk)
    begin
        if (rst_n)
        begin
            check({31'h0, $onehot({~topSel_n, ~midSel_n, ~botSel_n})}, 32'h1);
            if ({topSel_n, midSel_n, botSel_n} === selPrev)
                check({28'h0, bcd}, {28'h0, bcdPrev});
            if (integIn)
                check({31'h0, integRef}, 32'h0);
        end
        selPrev <= {topSel_n, midSel_n, botSel_n};
        bcdPrev <= bcd;
        inPrev  <= integIn;
        if (integIn === 1'b1)
            integLen <= (inPrev === 1'b1) ? integLen + 1 : 1;
    end

    // ======================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        modeSel = dsadc_pkg::MODE_SLOW;
        compAbove = 1'b0;
        rng = 32'd12473;
        n_fail = 0;
        n_compared = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({29'h0, topSel_n, midSel_n, botSel_n}, 32'h3);
        $display("test reset done");

        // Slow start while the mode wanders between codes 2'h0 and 2'h3, both slow
        n = 0;
        while (integIn !== 1'b1 && n < 8000)
        begin
            @(posedge clk);
            rng = xs(rng);
            modeSel <= rng[0] ? 2'h3 : 2'h0;
            n++;
        end
        check({31'h0, n >= dsadc_pkg::SLOW_TICKS * DIV
               && n <= dsadc_pkg::SLOW_TICKS * DIV + 4}, 32'h1);
        $display("test slow start done");

        // Negative input that never crosses back runs to the limit and overranges
        integrate(1'b0);
        waitRefDone(6000);
        check({31'h0, n >= (99 - 1) * TICK && n <= (99 + 2) * TICK}, 32'h1);
        repeat (9 * DIV) @(posedge clk);
        check({20'h0, topHeld, midHeld, botHeld}, {20'h0, {3{4'ha}}});
        $display("test negative overrange done");

        // Hold: a fresh small positive reading must not reach the digits
        modeSel <= dsadc_pkg::MODE_HOLD;
        n = 0;
        while (integIn !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        integrate(1'b1);
        rng = xs(rng);
        repeat ((5 + rng[3:0]) * TICK) @(posedge clk);
        compAbove <= 1'b0;
        waitRefDone(3000);
        check({31'h0, integRef}, 32'h0);
        repeat (9 * DIV) @(posedge clk);
        check({20'h0, topHeld, midHeld, botHeld}, {20'h0, {3{4'ha}}});
        $display("test hold done");

        // Mid-run reset into fast mode: the first start comes one fast period later
        rst_n   <= 1'b0;
        modeSel <= dsadc_pkg::MODE_FAST;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({29'h0, topSel_n, midSel_n, botSel_n}, 32'h3);
        n = 0;
        while (integIn !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n >= dsadc_pkg::FAST_TICKS * DIV
               && n <= dsadc_pkg::FAST_TICKS * DIV + 4}, 32'h1);
        $display("test fast start done");
        summarize();
    end
endmodule
`default_nettype wire
